// ==== rtl/ppo_pkg.sv ====
// Package for the pulse output next-data and trigger-select block
package ppo_pkg;
   // APB byte addresses of the register words
   localparam logic [7:0] ADDR_TRIG_SEL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_NEXT_EN_HIGH = 8'h08;
   localparam logic [7:0] ADDR_NEXT_EN_LOW = 8'h0c;
   localparam logic [7:0] ADDR_OUT_PAT_HIGH = 8'h10;
   localparam logic [7:0] ADDR_OUT_PAT_LOW = 8'h14;
   localparam logic [7:0] ADDR_NEXT_HIGH_A = 8'h18;
   localparam logic [7:0] ADDR_NEXT_HIGH_B = 8'h1c;
   localparam logic [7:0] ADDR_NEXT_LOW_A = 8'h20;
   localparam logic [7:0] ADDR_NEXT_LOW_B = 8'h24;

   // Reset values and read fill constants
   localparam logic [7:0] TRIG_SEL_RST = 8'hff;
   localparam logic [7:0] MODE_RST = 8'hf0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [15:0] ZERO_PAT = 16'h0000;
   localparam logic [3:0] NIBBLE_ONES = 4'hf;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;

   // Field positions in the trigger-select register
   localparam int G3_SEL_LSB = 6;
   localparam int G2_SEL_LSB = 4;
   localparam int G1_SEL_LSB = 2;
   localparam int G0_SEL_LSB = 0;
   // Non-overlap bits in the mode register
   localparam int G3_NOV_BIT = 3;
   localparam int G2_NOV_BIT = 2;

   localparam int NUM_GROUPS = 4;
   localparam int NUM_CH = 4;
   localparam int FIFO_DEPTH = 2;

   typedef logic [1:0] ppo_chan_t;

   // Compare-match events from the timer, one bit per channel
   typedef struct packed {
      logic [NUM_CH-1:0] cm_a;
      logic [NUM_CH-1:0] cm_b;
   } ppo_evt_t;

   // Snapshot of the output pattern after a transfer
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } ppo_pat_t;
endpackage : ppo_pkg

// ==== rtl/ppo_next_data.sv ====
// Next-data staging, trigger select and output pattern transfer
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Shared high layout: one byte address
// - Split high layout: nibbles at two addresses
// - Shared low layout: one byte address
// - Split low layout: nibbles at two addresses
// - Split layout unused nibble reads ones, ignored
// - Trigger copies high next bits to output
// - Trigger copies low next bits to output
// - Split high: 15:12 upper, 11:8 lower
// - Split low: 7:4 upper, 3:0 lower
// - Next-data bits read/write, reset zero
// - Eight-bit trigger-select register, per group
// - Bits 7:6 pick group 3 channel
// - Bits 5:4 pick group 2 channel
// - Only enabled bits are transferred
// - Enabled output bits are CPU read-only
// - Normal mode transfers on compare A
// - Non-overlap: A all, B zeros only
module ppo_next_data #(
   parameter ppo_pkg::ppo_chan_t LOW_GROUP_CHAN = 2'b11
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ppo_pkg::ppo_evt_t evt,
   input wire logic evt_valid,
   output logic evt_ready,
   output ppo_pkg::ppo_pat_t pat_out,
   output logic pat_valid,
   input wire logic pat_ready,
   output logic [15:0] pulse_out
);
   import ppo_pkg::*;

   logic [7:0] trig_sel_reg;
   logic [7:0] mode_reg;
   logic [7:0] next_en_high_reg;
   logic [7:0] next_en_low_reg;
   logic [15:0] next_pat_reg;
   logic [15:0] out_pat_reg;
   wire logic [15:0] out_pat_next;
   logic [31:0] prdata_reg;

   logic high_split;
   logic low_split;
   logic [15:0] next_en;
   logic take_evt;
   logic setup;
   logic access;
   logic wr;
   logic wr_lane0;
   logic mapped;
   logic [7:0] rd_byte;

   // Layout follows whether the paired groups' select fields match
   assign high_split = trig_sel_reg[G3_SEL_LSB +: 2] != trig_sel_reg[G2_SEL_LSB +: 2];
   assign low_split = trig_sel_reg[G1_SEL_LSB +: 2] != trig_sel_reg[G0_SEL_LSB +: 2];
   assign next_en = {next_en_high_reg, next_en_low_reg};

   // ---------------- APB slave ----------------
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite && !pslverr;
   assign wr_lane0 = wr && pstrb[0];
   // Zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = prdata_reg;

   always_comb begin
      mapped = 1'b1;
      rd_byte = ZERO_BYTE;
      unique case (paddr)
         ADDR_TRIG_SEL: rd_byte = trig_sel_reg;
         ADDR_MODE: rd_byte = mode_reg;
         ADDR_NEXT_EN_HIGH: rd_byte = next_en_high_reg;
         ADDR_NEXT_EN_LOW: rd_byte = next_en_low_reg;
         ADDR_OUT_PAT_HIGH: rd_byte = out_pat_reg[15:8];
         ADDR_OUT_PAT_LOW: rd_byte = out_pat_reg[7:0];
         ADDR_NEXT_HIGH_A: begin
            if (high_split) begin
               rd_byte = {next_pat_reg[15:12], NIBBLE_ONES};
            end else begin
               rd_byte = next_pat_reg[15:8];
            end
         end
         ADDR_NEXT_HIGH_B: begin
            // The second nibble address only exists in the split layout
            mapped = high_split;
            rd_byte = high_split ? {NIBBLE_ONES, next_pat_reg[11:8]} : ZERO_BYTE;
         end
         ADDR_NEXT_LOW_A: begin
            if (low_split) begin
               rd_byte = {next_pat_reg[7:4], NIBBLE_ONES};
            end else begin
               rd_byte = next_pat_reg[7:0];
            end
         end
         ADDR_NEXT_LOW_B: begin
            mapped = low_split;
            rd_byte = low_split ? {NIBBLE_ONES, next_pat_reg[3:0]} : ZERO_BYTE;
         end
         default: begin
            mapped = 1'b0;
            rd_byte = ZERO_BYTE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_reg <= '0;
      end else if (setup) begin
         prdata_reg <= {24'h000000, rd_byte};
      end
   end

   // Trigger select: all eight bits stored, low four only pick the low layout
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trig_sel_reg <= TRIG_SEL_RST;
      end else if (wr_lane0 && paddr == ADDR_TRIG_SEL) begin
         trig_sel_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg <= MODE_RST;
      end else if (wr_lane0 && paddr == ADDR_MODE) begin
         mode_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         next_en_high_reg <= ZERO_BYTE;
         next_en_low_reg <= ZERO_BYTE;
      end else begin
         if (wr_lane0 && paddr == ADDR_NEXT_EN_HIGH) begin
            next_en_high_reg <= pwdata[7:0];
         end
         if (wr_lane0 && paddr == ADDR_NEXT_EN_LOW) begin
            next_en_low_reg <= pwdata[7:0];
         end
      end
   end

   // Next-data writes, masked per nibble by the current layout
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         next_pat_reg <= ZERO_PAT;
      end else if (wr_lane0) begin
         unique case (paddr)
            ADDR_NEXT_HIGH_A: begin
               next_pat_reg[15:12] <= pwdata[7:4];
               if (!high_split) begin
                  next_pat_reg[11:8] <= pwdata[3:0];
               end
            end
            ADDR_NEXT_HIGH_B: begin
               if (high_split) begin
                  next_pat_reg[11:8] <= pwdata[3:0];
               end
            end
            ADDR_NEXT_LOW_A: begin
               next_pat_reg[7:4] <= pwdata[7:4];
               if (!low_split) begin
                  next_pat_reg[3:0] <= pwdata[3:0];
               end
            end
            ADDR_NEXT_LOW_B: begin
               if (low_split) begin
                  next_pat_reg[3:0] <= pwdata[3:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------- Trigger transfer per group ----------------
   // A stalled event stream holds the transfer so no trigger is dropped
   assign take_evt = evt_valid && evt_ready;

   generate
      for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
         ppo_chan_t sel;
         logic nov;
         logic hit_a;
         logic hit_b;
         logic [3:0] en;
         logic [3:0] nd;
         logic [3:0] cur;
         logic [3:0] cpu_val;
         logic cpu_wr;
         logic [3:0] nxt;

         if (g == 3) begin : g_sel3
            assign sel = trig_sel_reg[G3_SEL_LSB +: 2];
            assign nov = mode_reg[G3_NOV_BIT];
         end else if (g == 2) begin : g_sel2
            assign sel = trig_sel_reg[G2_SEL_LSB +: 2];
            assign nov = mode_reg[G2_NOV_BIT];
         end else begin : g_sel_low
            // Low groups ignore their reserved select fields
            assign sel = LOW_GROUP_CHAN;
            assign nov = 1'b0;
         end

         assign hit_a = take_evt && evt.cm_a[sel];
         assign hit_b = take_evt && nov && evt.cm_b[sel];
         assign en = next_en[4*g +: 4];
         assign nd = next_pat_reg[4*g +: 4];
         assign cur = out_pat_reg[4*g +: 4];
         assign cpu_wr = wr_lane0 && (paddr == ((g >= 2) ? ADDR_OUT_PAT_HIGH : ADDR_OUT_PAT_LOW));
         // CPU may only touch bits whose transfer is disabled
         assign cpu_val = (cur & en) | (pwdata[4*(g%2) +: 4] & ~en);

         always_comb begin
            nxt = cpu_wr ? cpu_val : cur;
            if (hit_a) begin
               // Compare A wins when both matches land together
               nxt = (nd & en) | (cur & ~en);
            end else if (hit_b) begin
               nxt = (cur & ~(en & ~nd));
            end
         end
         // One process per group, each driving only its own slice
         assign out_pat_next[4*g +: 4] = nxt;
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_pat_reg <= ZERO_PAT;
      end else begin
         out_pat_reg <= out_pat_next;
      end
   end

   assign pulse_out = out_pat_reg;

   // ---------------- Two-entry pattern buffer ----------------
   ppo_pat_t fifo_mem [FIFO_DEPTH];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   // Each accepted event queues the resulting pattern
   assign evt_ready = count_reg != 2'(FIFO_DEPTH);
   assign push = take_evt;
   assign pop = pat_valid && pat_ready;
   assign pat_valid = count_reg != 2'd0;
   assign pat_out = fifo_mem[rd_ptr_reg];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fifo_mem[0] <= '0;
         fifo_mem[1] <= '0;
      end else if (push) begin
         fifo_mem[wr_ptr_reg] <= out_pat_next;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'd0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         unique case ({push, pop})
            2'b10: count_reg <= count_reg + 2'd1;
            2'b01: count_reg <= count_reg - 2'd1;
            default: count_reg <= count_reg;
         endcase
      end
   end
endmodule : ppo_next_data

`default_nettype wire

// ==== verif/ppo_next_data_props.sv ====
// Port assertions for the next-data block
`timescale 1ns/1ps
`default_nettype none
module ppo_next_data_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic evt_valid,
   input wire logic evt_ready,
   input wire ppo_pkg::ppo_pat_t pat_out,
   input wire logic pat_valid,
   input wire logic pat_ready,
   input wire logic [15:0] pulse_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire logic take = evt_valid && evt_ready;
   wire logic cpu_wr = psel && penable && pwrite;
   property p_rst; $rose(arst_n) |-> pulse_out == 16'h0000 && !pat_valid; endproperty
   a_rst: assert property (p_rst) else $error("pattern not clear after reset");
   property p_quiet; !take && !cpu_wr |=> $stable(pulse_out); endproperty
   a_quiet: assert property (p_quiet) else $error("output moved without trigger");
   property p_push; take |=> pat_valid; endproperty
   a_push: assert property (p_push) else $error("taken event not buffered");
   property p_copy; take && !pat_valid |=> pat_out == pulse_out; endproperty
   a_copy: assert property (p_copy) else $error("buffered pattern differs");
   property p_hold; pat_valid && !pat_ready |=> pat_valid && $stable(pat_out); endproperty
   a_hold: assert property (p_hold) else $error("pattern lost in stall");
   property p_full; !evt_ready && !pat_ready |=> !evt_ready; endproperty
   a_full: assert property (p_full) else $error("full buffer took event");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access phase");
   property p_rd; psel && penable && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
   a_rd: assert property (p_rd) else $error("read data upper bits set");
endmodule : ppo_next_data_chk
bind ppo_next_data ppo_next_data_chk i_chk (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .evt_valid(evt_valid), .evt_ready(evt_ready),
   .pat_out(pat_out), .pat_valid(pat_valid), .pat_ready(pat_ready), .pulse_out(pulse_out));
`default_nettype wire

// ==== verif/ppo_far_model.sv ====
// Timer event source and pattern consumer facing the block
`timescale 1ns/1ps
`default_nettype none
module ppo_far_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire ppo_pkg::ppo_evt_t evt_cmd,
   input wire logic go,
   input wire logic stall,
   output var ppo_pkg::ppo_evt_t evt,
   output logic evt_valid,
   input wire logic evt_ready,
   output logic pat_ready
);
   // Once taken, the event lines carry garbage, never the old code
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         evt <= 8'h00;
         evt_valid <= 1'b0;
      end else if (go) begin
         evt <= evt_cmd;
         evt_valid <= 1'b1;
      end else if (evt_valid && evt_ready) begin
         evt <= ~evt;
         evt_valid <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) pat_ready <= 1'b0;
      else pat_ready <= !stall;
   end
endmodule : ppo_far_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// Directed bench for the next-data block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ppo_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic go = 1'b0;
   logic stall = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready, pslverr, evt_valid, evt_ready, pat_valid, pat_ready, err;
   ppo_evt_t evt;
   ppo_evt_t evt_cmd = 8'h00;
   ppo_pat_t pat_out;
   logic [15:0] pulse_out;
   logic [7:0] prev;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   ppo_next_data i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .evt(evt), .evt_valid(evt_valid), .evt_ready(evt_ready), .pat_out(pat_out), .pat_valid(pat_valid),
      .pat_ready(pat_ready), .pulse_out(pulse_out));
   ppo_far_model i_far (.clk(clk), .arst_n(arst_n), .evt_cmd(evt_cmd), .go(go), .stall(stall), .evt(evt),
      .evt_valid(evt_valid), .evt_ready(evt_ready), .pat_ready(pat_ready));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Read data and error are taken at the edge that samples pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      chk(w ? {31'h0, pslverr} : prdata, w ? 32'h0 : {24'h000000, d});
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic fire(input logic [7:0] e);
      @(posedge clk);
      go <= 1'b1;
      evt_cmd <= e;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (evt_valid);
   endtask : fire
   task automatic po(input logic [15:0] e);
      chk({16'h0000, pulse_out}, {16'h0000, e});
   endtask : po
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      po(ZERO_PAT);
      apb(1'b0, ADDR_TRIG_SEL, TRIG_SEL_RST);
      apb(1'b0, ADDR_NEXT_HIGH_A, ZERO_BYTE);
      apb(1'b0, ADDR_NEXT_LOW_A, ZERO_BYTE);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'ha5);
      apb(1'b0, ADDR_NEXT_HIGH_A, 8'ha5);
      apb(1'b0, ADDR_NEXT_HIGH_B, 8'h00);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h40, 8'h00);
      chk({31'h0, err}, 32'h1);
      // Write without the low byte lane must leave the register alone
      pstrb <= 4'he;
      apb(1'b1, ADDR_TRIG_SEL, 8'h00);
      pstrb <= 4'hf;
      apb(1'b0, ADDR_TRIG_SEL, TRIG_SEL_RST);
      apb(1'b1, ADDR_NEXT_LOW_A, 8'h3c);
      apb(1'b0, ADDR_NEXT_LOW_A, 8'h3c);
      apb(1'b1, ADDR_NEXT_EN_HIGH, 8'hff);
      apb(1'b1, ADDR_NEXT_EN_LOW, 8'hff);
      fire(8'h80);
      po(16'ha53c);
      apb(1'b1, ADDR_OUT_PAT_HIGH, 8'h00);
      apb(1'b0, ADDR_OUT_PAT_HIGH, 8'ha5);
      apb(1'b1, ADDR_NEXT_EN_HIGH, 8'h0f);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'h5a);
      fire(8'h80);
      po(16'haa3c);
      fire(8'h08);
      po(16'haa3c);
      apb(1'b1, ADDR_NEXT_EN_HIGH, 8'hff);
      prev = 8'haa;
      // Each select code: the wrong channel must leave the output alone
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_TRIG_SEL, {c[1:0], c[1:0], 4'hf});
         apb(1'b1, ADDR_NEXT_HIGH_A, {c[3:0], 4'h6});
         fire(8'(8'h10 << ((c + 1) % 4)));
         po({prev, 8'h3c});
         fire(8'(8'h10 << c));
         prev = {c[3:0], 4'h6};
         po({prev, 8'h3c});
      end
      apb(1'b1, ADDR_TRIG_SEL, 8'h9f);
      apb(1'b0, ADDR_TRIG_SEL, 8'h9f);
      apb(1'b0, ADDR_NEXT_HIGH_A, 8'h3f);
      apb(1'b0, ADDR_NEXT_HIGH_B, 8'hf6);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'hc0);
      apb(1'b1, ADDR_NEXT_HIGH_B, 8'h09);
      apb(1'b0, ADDR_NEXT_HIGH_A, 8'hcf);
      apb(1'b0, ADDR_NEXT_HIGH_B, 8'hf9);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'hc0);
      apb(1'b0, ADDR_NEXT_HIGH_B, 8'hf9);
      fire(8'h40);
      po(16'hc63c);
      fire(8'h20);
      po(16'hc93c);
      apb(1'b1, ADDR_TRIG_SEL, 8'hff);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'hff);
      fire(8'h80);
      apb(1'b1, ADDR_MODE, 8'hf8);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'h5a);
      fire(8'h08);
      po(16'h5f3c);
      fire(8'h80);
      po(16'h5a3c);
      apb(1'b1, ADDR_MODE, 8'hf4);
      apb(1'b1, ADDR_NEXT_HIGH_A, 8'ha0);
      fire(8'h08);
      po(16'h503c);
      apb(1'b1, ADDR_TRIG_SEL, 8'hfb);
      apb(1'b0, ADDR_TRIG_SEL, 8'hfb);
      apb(1'b0, ADDR_NEXT_LOW_A, 8'h3f);
      apb(1'b1, ADDR_NEXT_LOW_A, 8'h90);
      apb(1'b1, ADDR_NEXT_LOW_B, 8'h06);
      apb(1'b0, ADDR_NEXT_LOW_A, 8'h9f);
      apb(1'b0, ADDR_NEXT_LOW_B, 8'hf6);
      fire(8'h80);
      po(16'ha096);
      // Consumer stalls: two words fill the buffer, a third must wait
      @(posedge clk);
      stall <= 1'b1;
      fire(8'h80);
      fire(8'h80);
      chk({31'h0, evt_ready}, 32'h0);
      fork
         fire(8'h80);
         begin
            repeat (6) @(posedge clk);
            stall <= 1'b0;
         end
      join
      repeat (6) @(posedge clk);
      chk({31'h0, pat_valid}, 32'h0);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
